// >>> design/dcw_top.sv
// Purpose: four-channel discrete I/O control with watchdogs and AXI4-Lite registers
// Assumes: inputs synchronous to i_clk, one AXI transaction per direction at a time
// Notes: timebase length is a parameter so simulation can shorten a second
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dcw_top
	import dcw_pkg::*;
#(
	parameter int unsigned P_SEC_CYCLES = SEC_CYCLES
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [NCH-1:0] i_din,
	input wire logic [NCH-1:0] i_thermal_trip,
	input wire logic i_excit,
	output logic [NCH-1:0] o_dout,
	output logic [NCH-1:0] o_range_4_20,
	output logic o_irq
);
	// watchdog enabled only for the documented live range
	function automatic logic wdt_on(input logic [15:0] p);
		return (p != WDT_OFF_LO) && (p != WDT_OFF_HI);
	endfunction

	function automatic logic is_wdt(input logic [7:0] a);
		return (a[7:4] == WDT_PAGE) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic is_label(input logic [7:0] a);
		return (a[7:5] == LABEL_PAGE) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return is_wdt(a) || is_label(a) || (a[7:5] == 3'h0 && a[1:0] == 2'h0);
	endfunction

	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// bus write state
	logic [7:0] awaddr_q, next_awaddr_q;
	logic [31:0] wdata_q, next_wdata_q;
	logic [3:0] wstrb_q, next_wstrb_q;
	logic aw_full, next_aw_full, w_full, next_w_full;
	logic next_awready, next_wready, next_bvalid;
	logic [1:0] next_bresp;
	logic do_wr;
	// bus read state
	dcw_rd_e rd_st, next_rd_st;
	logic [7:0] araddr_q, next_araddr_q;
	logic next_arready, next_rvalid, rd_touch, mem_re;
	logic [31:0] next_rdata, mem_rdata;
	logic [1:0] next_rresp;
	// channel state
	logic refresh_en, next_refresh_en;
	logic [NCH-1:0] out_val, next_out_val, inv, next_inv, safe, next_safe;
	logic [NCH-1:0] next_range, timed_out, next_timed_out, prot, next_prot;
	logic [NCH-1:0] therm, next_therm, next_dout;
	logic [15:0] wdt_period [NCH];
	logic [15:0] next_wdt_period [NCH];
	logic [15:0] wdt_cnt [NCH];
	logic [15:0] next_wdt_cnt [NCH];
	logic [7:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic excit_q, tick, next_tick, next_irq, touch_all;
	logic [31:0] div_cnt, next_div_cnt;

	assign do_wr = aw_full && w_full && !o_s_axi_bvalid;

	// write channels are taken independently, answer after both are held
	always_comb
	begin
		next_awaddr_q = awaddr_q;
		next_wdata_q = wdata_q;
		next_wstrb_q = wstrb_q;
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_bvalid = o_s_axi_bvalid;
		next_bresp = o_s_axi_bresp;
		if (i_s_axi_awvalid && o_s_axi_awready)
		begin
			next_awaddr_q = i_s_axi_awaddr;
			next_aw_full = 1'b1;
		end
		if (i_s_axi_wvalid && o_s_axi_wready)
		begin
			next_wdata_q = i_s_axi_wdata;
			next_wstrb_q = i_s_axi_wstrb;
			next_w_full = 1'b1;
		end
		if (do_wr)
		begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (o_s_axi_bvalid && i_s_axi_bready)
		begin
			next_bvalid = 1'b0;
		end
		// ready held low while a response is pending keeps one write in flight
		next_awready = !next_aw_full && !next_bvalid;
		next_wready = !next_w_full && !next_bvalid;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			awaddr_q <= next_awaddr_q;
			wdata_q <= next_wdata_q;
			wstrb_q <= next_wstrb_q;
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			o_s_axi_awready <= next_awready;
			o_s_axi_wready <= next_wready;
			o_s_axi_bvalid <= next_bvalid;
			o_s_axi_bresp <= next_bresp;
		end
	end

	// label words live in their own memory with a registered read
	assign mem_re = (rd_st == RD_IDLE) && o_s_axi_arready && i_s_axi_arvalid;

	dcw_label_mem dcw_label_mem_i (
		.i_clk(i_clk),
		.i_we(do_wr && is_label(awaddr_q)),
		.i_waddr(awaddr_q[4:2]),
		.i_wdata(wdata_q),
		.i_wstrb(wstrb_q),
		.i_re(mem_re),
		.i_raddr(i_s_axi_araddr[4:2]),
		.o_rdata(mem_rdata)
	);

	// read: take address, fetch one cycle, then hold data until rready
	always_comb
	begin
		next_rd_st = rd_st;
		next_araddr_q = araddr_q;
		next_rdata = o_s_axi_rdata;
		next_rresp = o_s_axi_rresp;
		next_rvalid = o_s_axi_rvalid;
		rd_touch = 1'b0;
		case (rd_st)
			RD_IDLE:
			begin
				if (mem_re)
				begin
					next_araddr_q = i_s_axi_araddr;
					next_rd_st = RD_FETCH;
				end
			end
			RD_FETCH:
			begin
				next_rvalid = 1'b1;
				next_rresp = addr_ok(araddr_q) ? RESP_OKAY : RESP_SLVERR;
				next_rdata = 32'h0000_0000;
				rd_touch = (araddr_q == ADDR_OUT) || (araddr_q == ADDR_IN);
				if (is_wdt(araddr_q))
				begin
					next_rdata[15:0] = wdt_period[araddr_q[3:2]];
				end
				else if (is_label(araddr_q))
				begin
					next_rdata = mem_rdata;
				end
				else
				begin
					case (araddr_q)
						ADDR_CTRL: next_rdata[CTRL_REFRESH_BIT] = refresh_en;
						ADDR_OUT: next_rdata[NCH-1:0] = out_val;
						ADDR_IN:
						begin
							next_rdata[STAT_IN_LSB +: NCH] = i_din ^ inv;
							next_rdata[STAT_OUT_LSB +: NCH] = o_dout;
							next_rdata[STAT_TMO_LSB +: NCH] = timed_out;
							next_rdata[STAT_PROT_LSB +: NCH] = prot;
							next_rdata[STAT_THERM_LSB +: NCH] = therm;
						end
						ADDR_INV: next_rdata[NCH-1:0] = inv;
						ADDR_SAFE: next_rdata[NCH-1:0] = safe;
						ADDR_RANGE: next_rdata[NCH-1:0] = o_range_4_20;
						ADDR_IRQ_STAT: next_rdata[7:0] = irq_stat;
						ADDR_IRQ_MASK: next_rdata[7:0] = irq_mask;
						default: next_rdata = 32'h0000_0000;
					endcase
				end
				next_rd_st = RD_RESP;
			end
			RD_RESP:
			begin
				if (i_s_axi_rready)
				begin
					next_rvalid = 1'b0;
					next_rd_st = RD_IDLE;
				end
			end
			default: next_rd_st = RD_IDLE;
		endcase
		next_arready = (next_rd_st == RD_IDLE);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			rd_st <= RD_IDLE;
			araddr_q <= 8'h00;
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			rd_st <= next_rd_st;
			araddr_q <= next_araddr_q;
			o_s_axi_arready <= next_arready;
			o_s_axi_rvalid <= next_rvalid;
			o_s_axi_rdata <= next_rdata;
			o_s_axi_rresp <= next_rresp;
		end
	end

	// channel data access from either direction restarts every watchdog
	assign touch_all = rd_touch || (do_wr && (awaddr_q == ADDR_OUT || awaddr_q == ADDR_IN));

	// channel configuration, watchdogs, protection latches and interrupts
	always_comb
	begin
		next_refresh_en = refresh_en;
		next_out_val = out_val;
		next_inv = inv;
		next_safe = safe;
		next_range = o_range_4_20;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_timed_out = timed_out;
		next_prot = prot;
		next_therm = therm;
		next_wdt_period = wdt_period;
		next_wdt_cnt = wdt_cnt;
		// a 32-bit divider makes the one-second enable pulse
		next_tick = (div_cnt == 32'(P_SEC_CYCLES - 1));
		next_div_cnt = next_tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
		if (do_wr && wstrb_q[0])
		begin
			case (awaddr_q)
				ADDR_CTRL: next_refresh_en = wdata_q[CTRL_REFRESH_BIT];
				ADDR_OUT:
				begin
					next_out_val = wdata_q[NCH-1:0];
					next_therm = CH_RST;
				end
				ADDR_INV: next_inv = wdata_q[NCH-1:0];
				ADDR_SAFE: next_safe = wdata_q[NCH-1:0];
				ADDR_RANGE: next_range = wdata_q[NCH-1:0];
				ADDR_IRQ_MASK: next_irq_mask = wdata_q[7:0];
				ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~wdata_q[7:0];
				default: next_refresh_en = refresh_en;
			endcase
		end
		// a refresh tick rewrites outputs from out_val, clearing a thermal latch
		if (refresh_en && tick)
		begin
			next_therm = CH_RST;
		end
		for (int i = 0; i < NCH; i++)
		begin
			if (do_wr && is_wdt(awaddr_q) && awaddr_q[3:2] == 2'(i))
			begin
				next_wdt_period[i] = wr16(wdt_period[i], wdata_q, wstrb_q);
			end
			if (!wdt_on(next_wdt_period[i]))
			begin
				next_wdt_cnt[i] = next_wdt_period[i];
				next_timed_out[i] = 1'b0;
			end
			else if (touch_all || next_wdt_period[i] != wdt_period[i])
			begin
				next_wdt_cnt[i] = next_wdt_period[i];
				next_timed_out[i] = 1'b0;
			end
			else if (tick && !timed_out[i])
			begin
				if (wdt_cnt[i] == 16'h0001)
				begin
					// expiry writes the safe level into the output value itself
					next_timed_out[i] = 1'b1;
					next_out_val[i] = safe[i];
					next_wdt_cnt[i] = 16'h0000;
					next_irq_stat[IRQ_TMO_LSB + i] = 1'b1;
				end
				else
				begin
					next_wdt_cnt[i] = wdt_cnt[i] - 16'h0001;
				end
			end
			// excitation rising edge releases the latch; a new contention wins
			if (i_excit && !excit_q)
			begin
				next_prot[i] = 1'b0;
			end
			if (i_din[i] && o_dout[i])
			begin
				next_prot[i] = 1'b1;
				next_irq_stat[IRQ_PROT_LSB + i] = !prot[i] || irq_stat[IRQ_PROT_LSB + i];
			end
			if (i_thermal_trip[i])
			begin
				next_therm[i] = 1'b1;
			end
		end
		// output polarity ignores input inversion
		next_dout = next_out_val & ~next_prot & ~next_therm;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			refresh_en <= 1'b0;
			out_val <= CH_RST;
			inv <= CH_RST;
			safe <= CH_RST;
			o_range_4_20 <= CH_RST;
			irq_mask <= IRQ_RST;
			irq_stat <= IRQ_RST;
			timed_out <= CH_RST;
			prot <= CH_RST;
			therm <= CH_RST;
			o_dout <= CH_RST;
			o_irq <= 1'b0;
			// idle level is excitation present, so release makes no false edge
			excit_q <= 1'b1;
			tick <= 1'b0;
			div_cnt <= 32'h0000_0000;
			for (int i = 0; i < NCH; i++)
			begin
				wdt_period[i] <= WDT_RST;
				wdt_cnt[i] <= WDT_RST;
			end
		end
		else
		begin
			refresh_en <= next_refresh_en;
			out_val <= next_out_val;
			inv <= next_inv;
			safe <= next_safe;
			o_range_4_20 <= next_range;
			irq_mask <= next_irq_mask;
			irq_stat <= next_irq_stat;
			timed_out <= next_timed_out;
			prot <= next_prot;
			therm <= next_therm;
			o_dout <= next_dout;
			o_irq <= next_irq;
			excit_q <= i_excit;
			tick <= next_tick;
			div_cnt <= next_div_cnt;
			wdt_period <= next_wdt_period;
			wdt_cnt <= next_wdt_cnt;
		end
	end
endmodule

// >>> pkg/dcw_pkg.sv
// Purpose: shared constants and types for the discrete channel watchdog block
// Assumes: 50 MHz system clock, 32-bit AXI4-Lite register access
// Notes: all offsets are byte addresses of aligned 32-bit words
package dcw_pkg;
	localparam int NCH = 4;
	localparam int ADDR_W = 8;
	localparam int LABEL_WORDS = 8;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SECOND_NS = 1_000_000_000;
	// one-second timebase, exact division of the clock period
	localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OUT = 8'h04;
	localparam logic [7:0] ADDR_IN = 8'h08;
	localparam logic [7:0] ADDR_INV = 8'h0c;
	localparam logic [7:0] ADDR_SAFE = 8'h10;
	localparam logic [7:0] ADDR_RANGE = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
	localparam logic [3:0] WDT_PAGE = 4'h2;
	localparam logic [2:0] LABEL_PAGE = 3'h2;
	// field positions
	localparam int CTRL_REFRESH_BIT = 0;
	localparam int STAT_IN_LSB = 0;
	localparam int STAT_OUT_LSB = 4;
	localparam int STAT_TMO_LSB = 8;
	localparam int STAT_PROT_LSB = 12;
	localparam int STAT_THERM_LSB = 16;
	localparam int IRQ_TMO_LSB = 0;
	localparam int IRQ_PROT_LSB = 4;
	// reset values and watchdog codes
	localparam logic [15:0] WDT_OFF_LO = 16'h0000;
	localparam logic [15:0] WDT_OFF_HI = 16'hffff;
	localparam logic [15:0] WDT_RST = 16'h0000;
	localparam logic [3:0] CH_RST = 4'h0;
	localparam logic [7:0] IRQ_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} dcw_rd_e;
endpackage

// >>> design/dcw_label_mem.sv
// Purpose: small word memory holding the per-channel text labels
// Assumes: one write port with byte enables, one registered read port
// Notes: contents have no reset; software owns them entirely
`timescale 1ns/1ns
module dcw_label_mem
	import dcw_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [2:0] i_waddr,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_re,
	input wire logic [2:0] i_raddr,
	output logic [31:0] o_rdata
);
	logic [31:0] mem [LABEL_WORDS];

	// byte-lane write and registered read
	always_ff @(posedge i_clk)
	begin
		for (int b = 0; b < 4; b++)
		begin
			if (i_we && i_wstrb[b])
			begin
				mem[i_waddr][8*b +: 8] <= i_wdata[8*b +: 8];
			end
		end
		if (i_re)
		begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule

// >>> verif/dcw_top_properties.sv
// Purpose: port-level checks for the channel watchdog block
// Assumes: one clock, synchronous active-low reset
// Notes: contention watched on channel 3, thermal trip on channel 2
`timescale 1ns/1ns
module dcw_top_properties
	import dcw_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [NCH-1:0] i_din,
	input wire logic [NCH-1:0] i_thermal_trip,
	input wire logic [NCH-1:0] o_dout,
	input wire logic o_irq
);
	// single domain, so clock and reset are given once
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// field-side protection: output off on the next edge; a later release may follow
	contend_off_a: assert property (o_dout[3] && i_din[3] |-> ##1 !o_dout[3])
		else $error("output kept on while its input was driven");
	thermal_off_a: assert property (i_thermal_trip[2] |-> ##1 !o_dout[2])
		else $error("output kept on after thermal trip");
	// register bus timing as handed over
	wr_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
		&& o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("write answer late");
	b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
		else $error("write answer dropped early");
	b_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while answer pending");
	rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
		|=> !o_s_axi_rvalid ##1 o_s_axi_rvalid) else $error("read answer not on second edge");
	r_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer not held");
	r_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken while answer pending");
	cover property (o_dout[3] && i_din[3]);
	cover property ($rose(o_irq));
	cover property (i_thermal_trip[2] && o_dout[2]);
endmodule

// >>> verif/dcw_host.sv
// Purpose: host-side register master for the watchdog block
// Assumes: one transfer per direction at a time
// Notes: released payloads are inverted so stale values never look valid
`timescale 1ns/1ns
module dcw_host
	import dcw_pkg::*;
(
	input wire logic i_clk,
	output logic [ADDR_W-1:0] o_awaddr,
	output logic o_awvalid,
	input wire logic i_awready,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	output logic o_wvalid,
	input wire logic i_wready,
	input wire logic [1:0] i_bresp,
	input wire logic i_bvalid,
	output logic o_bready,
	output logic [ADDR_W-1:0] o_araddr,
	output logic o_arvalid,
	input wire logic i_arready,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	input wire logic i_rvalid,
	output logic o_rready
);
	// idle bus from time zero
	initial
	begin
		{o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
	end
	// address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
		input logic [3:0] s = 4'hf);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge i_clk);
		o_awaddr <= a;
		o_wdata <= d;
		o_wstrb <= s;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		do
		begin
			@(posedge i_clk);
			if (!aw && i_awready)
			begin
				aw = 1'b1;
				o_awvalid <= 1'b0;
				o_awaddr <= ~a;
			end
			if (!w && i_wready)
			begin
				w = 1'b1;
				o_wvalid <= 1'b0;
				o_wdata <= ~d;
			end
		end
		while (!(aw && w));
		do @(posedge i_clk); while (!i_bvalid);
		r = i_bresp;
		o_bready <= 1'b0;
	endtask
	// ready held up until the answer is sampled
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		do @(posedge i_clk); while (!i_arready);
		o_arvalid <= 1'b0;
		o_araddr <= ~a;
		do @(posedge i_clk); while (!i_rvalid);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule

// >>> verif/tb_dcw_top.sv
// Purpose: self-checking bench for the channel watchdog block
// Assumes: a second shortened to SEC clocks
// Notes: the host model carries every bus cycle
`timescale 1ns/1ns
module tb_dcw_top
	import dcw_pkg::*;
;
	localparam int SEC = 20;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] din = 4'h0;
	logic [3:0] trip = 4'h0;
	logic excit = 1'b1;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdt, d;
	logic [3:0] ws, dout, rng;
	logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq;
	logic [1:0] bre, rre, rs;
	logic [7:0] zr [9] = '{ADDR_CTRL, ADDR_OUT, ADDR_INV, ADDR_SAFE, ADDR_RANGE,
		ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h20, 8'h2c};
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc_n = 0;
	dcw_top #(.P_SEC_CYCLES(SEC)) dcw_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
		.o_s_axi_bresp(bre), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
		.i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
		.o_s_axi_rdata(rdt), .o_s_axi_rresp(rre), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
		.i_din(din), .i_thermal_trip(trip), .i_excit(excit), .o_dout(dout),
		.o_range_4_20(rng), .o_irq(irq));
	dcw_host dcw_host_i (.i_clk(i_clk), .o_awaddr(awa), .o_awvalid(awv), .i_awready(awr),
		.o_wdata(wd), .o_wstrb(ws), .o_wvalid(wv), .i_wready(wr), .i_bresp(bre),
		.i_bvalid(bv), .o_bready(br), .o_araddr(ara), .o_arvalid(arv), .i_arready(arr),
		.i_rdata(rdt), .i_rresp(rre), .i_rvalid(rv), .o_rready(rr));
	// 50 MHz
	always #10 i_clk = ~i_clk;
	// hang guard, far above the few hundred cycles needed
	always @(posedge i_clk)
	begin
		cyc_n++;
		if (cyc_n == 8000)
		begin
			error_cnt++;
			$display("[ERR] %0t run did not finish", $time);
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] v);
		dcw_host_i.wr(a, v, rs);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		dcw_host_i.rd(a, d, rs);
		chk(d & m, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// main sequence; inputs change by non-blocking assignment at edges
	initial
	begin
		cyc(16);
		i_rst_n <= 1'b1;
		cyc(2);
		foreach (zr[k])
			rc(zr[k], 32'hffffffff, 32'h0);
		rc(8'h30, 32'hffffffff, 32'h0);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		w(8'h30, 32'h1);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		w(ADDR_RANGE, 32'ha);
		cyc(2);
		chk({28'h0, rng}, 32'ha);
		// inversion touches the input path only
		din <= 4'h3;
		w(ADDR_INV, 32'h5);
		rc(ADDR_IN, 32'hf, 32'h6);
		din <= 4'h0;
		w(ADDR_INV, 32'hf);
		w(ADDR_OUT, 32'h5);
		cyc(2);
		chk({28'h0, dout}, 32'h5);
		rc(ADDR_IN, 32'hff, 32'h5f);
		w(8'h48, 32'h6c616231);
		rc(8'h48, 32'hffffffff, 32'h6c616231);
		chk({28'h0, dout}, 32'h5);
		// ch0 short period, ch1..3 off or very long
		w(ADDR_IRQ_MASK, 32'h1);
		w(ADDR_SAFE, 32'h1);
		w(8'h20, 32'h3);
		w(8'h28, 32'hffff);
		w(8'h2c, 32'hfffe);
		w(ADDR_OUT, 32'he);
		repeat (5)
		begin
			cyc(SEC);
			rc(ADDR_OUT, 32'hf, 32'he);
		end
		cyc(3 * SEC / 2);
		chk({28'h0, dout}, 32'he);
		cyc(7 * SEC / 4);
		chk({28'h0, dout}, 32'hf);
		chk({31'h0, irq}, 32'h1);
		w(8'h20, 32'h0);
		w(ADDR_IRQ_MASK, 32'h0);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		w(ADDR_IRQ_MASK, 32'h1);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		w(ADDR_IRQ_STAT, 32'h1);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		// thermal latch holds until refresh is turned on
		trip <= 4'h4;
		cyc(1);
		trip <= 4'h0;
		cyc(3);
		chk({28'h0, dout}, 32'hb);
		cyc(2 * SEC);
		chk({28'h0, dout}, 32'hb);
		w(ADDR_CTRL, 32'h1);
		cyc(SEC + 5);
		chk({28'h0, dout}, 32'hf);
		// contention survives writes and refresh, cleared by excitation cycling
		din <= 4'h8;
		cyc(4);
		din <= 4'h0;
		chk({28'h0, dout}, 32'h7);
		w(ADDR_OUT, 32'hf);
		cyc(SEC + 5);
		chk({28'h0, dout}, 32'h7);
		rc(ADDR_IRQ_STAT, 32'hf0, 32'h80);
		chk({31'h0, irq}, 32'h0);
		excit <= 1'b0;
		cyc(2);
		excit <= 1'b1;
		cyc(3);
		chk({28'h0, dout}, 32'hf);
		// byte lanes: each strobe writes only its own half of a period
		dcw_host_i.wr(8'h24, 32'h1234, rs, 4'h1);
		dcw_host_i.wr(8'h24, 32'h5600, rs, 4'h2);
		rc(8'h24, 32'hffffffff, 32'h5634);
		test_done();
	end
endmodule
bind dcw_top dcw_top_properties dcw_top_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
	.i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
	.o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
	.i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rvalid(o_s_axi_rvalid),
	.i_s_axi_rready(i_s_axi_rready), .i_din(i_din), .i_thermal_trip(i_thermal_trip),
	.o_dout(o_dout), .o_irq(o_irq));
